// ==== hw/rbm_pkg.sv ====
package rbm_pkg;
  // Special function register addresses
  localparam logic [7:0] OFS_PAGE_SELECT = 8'h85;
  localparam logic [7:0] OFS_BANK_CONTROL = 8'h86;
  localparam logic [7:0] OFS_SYS_CONFIG = 8'hBF;
  // Reset values
  localparam logic [3:0] RST_PAGE_FIELD = 4'h0;
  localparam logic [5:0] RST_BANK_FIELD = 6'h01;
  localparam logic RST_WINDOW_ENABLE = 1'b0;
  localparam logic RST_XRAM_ENABLE = 1'b0;
  localparam logic RST_ALE_INHIBIT = 1'b0;
  localparam logic RST_WDT_FLAG = 1'b0;
  // Field positions
  localparam int POS_WINDOW_ENABLE = 7;
  localparam int POS_XRAM_ENABLE = 1;
  localparam int POS_ALE_INHIBIT = 0;
  localparam int POS_WDT_FLAG = 7;
  // Memory map
  localparam logic [7:0] WIN_BASE = 8'h40;
  localparam logic [7:0] WIN_LAST = 8'h7F;
  localparam logic [7:0] SFR_BASE = 8'h80;
  localparam logic [15:0] XRAM_LAST = 16'h0EFF;
  localparam logic [3:0] PAGE_INVALID = 4'hF;
  localparam logic [5:0] BANK_FIRST_XRAM = 6'h04;
  localparam logic [11:0] XRAM_ARRAY_BASE = 12'h100;
  localparam int RAM_WORDS = 4096;
endpackage

// ==== hw/rbm_ram.sv ====
`timescale 1ns/10ps
// Single-port byte RAM with registered read data
module rbm_ram #(
  parameter int AW = 12
) (
  input wire logic clk_sys,
  input wire logic wrEn,
  input wire logic rdEn,
  input wire logic [AW-1:0] addr,
  input wire logic [7:0] wrData,
  output logic [7:0] rdData_q
);
  logic [7:0] mem [0:(1<<AW)-1];

  // Write port
  always_ff @(posedge clk_sys) begin
    if (wrEn) begin
      mem[addr] <= wrData;
    end
  end

  // Registered read
  always_ff @(posedge clk_sys) begin
    if (rdEn) begin
      rdData_q <= mem[addr];
    end
  end
endmodule

// ==== hw/rbm_sfr_regs.sv ====
`timescale 1ns/10ps
// Holds the three mapping registers on the core's SFR port
module rbm_sfr_regs
  import rbm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic sfrWr,
  input wire logic [7:0] sfrAddr,
  input wire logic [7:0] sfrWrData,
  input wire logic wdtResetSeen,
  output logic [3:0] pageField_q,
  output logic [5:0] bankField_q,
  output logic windowEnable_q,
  output logic xramEnable_q,
  output logic aleInhibit_q,
  output logic wdtFlag_q
);
  // Page select register
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pageField_q <= RST_PAGE_FIELD;
    end else if (sfrWr && sfrAddr == OFS_PAGE_SELECT) begin
      pageField_q <= sfrWrData[3:0];
    end
  end

  // Window bank control register
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      bankField_q <= RST_BANK_FIELD;
      windowEnable_q <= RST_WINDOW_ENABLE;
    end else if (sfrWr && sfrAddr == OFS_BANK_CONTROL) begin
      bankField_q <= sfrWrData[5:0];
      windowEnable_q <= sfrWrData[POS_WINDOW_ENABLE];
    end
  end

  // System configuration; watchdog flag set wins over clear
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      xramEnable_q <= RST_XRAM_ENABLE;
      aleInhibit_q <= RST_ALE_INHIBIT;
      wdtFlag_q <= RST_WDT_FLAG;
    end else begin
      if (sfrWr && sfrAddr == OFS_SYS_CONFIG) begin
        xramEnable_q <= sfrWrData[POS_XRAM_ENABLE];
        aleInhibit_q <= sfrWrData[POS_ALE_INHIBIT];
        wdtFlag_q <= sfrWrData[POS_WDT_FLAG] | wdtResetSeen;
      end else if (wdtResetSeen) begin
        wdtFlag_q <= 1'b1;
      end
    end
  end
endmodule

// ==== hw/rbm_bank_mapper.sv ====
`timescale 1ns/10ps
// Contract
// - 4 KB RAM: 256 core plus 3840 expanded
// - 00h-7Fh reachable direct and indirect
// - Register, bit and general areas below 80h
// - Upper 128 bytes indirect or window only
// - Direct 80h-FFh goes to SFR space
// - Expanded RAM at external 0000h-0EFFh on chip
// - Enabled window maps direct 40h-7Fh to bank
// - Banks 0-3 map core RAM 000h-0FFh
// - Banks 4-63 map expanded RAM blocks
// - Window disabled leaves ordinary lower RAM
// - Page field gives upper external address byte
// - Expanded enable bit 1, resets off
// - On-chip accesses leave bus request and write strobes idle
module rbm_bank_mapper
  import rbm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic iramReq,
  input wire logic iramIndirect,
  input wire logic iramWr,
  input wire logic [7:0] iramAddr,
  input wire logic [7:0] iramWrData,
  output logic [7:0] iramRdData_q,
  output logic iramRdValid_q,
  input wire logic xdataReq,
  input wire logic xdataWr,
  input wire logic xdataByReg,
  input wire logic [15:0] xdataAddr,
  input wire logic [7:0] xdataWrData,
  output logic [7:0] xdataRdData_q,
  output logic xdataRdValid_q,
  output logic xdataExtReq,
  output logic xdataExtWr,
  output logic [15:0] xdataExtAddr,
  output logic [7:0] xdataExtWrData,
  output logic sfrReq,
  output logic sfrWr,
  output logic [7:0] sfrAddr,
  output logic [7:0] sfrWrData,
  input wire logic [7:0] sfrExtRdData,
  input wire logic wdtResetSeen,
  output logic xramEnable,
  output logic aleInhibit
);
  logic [3:0] pageField_q;
  logic [5:0] bankField_q;
  logic windowEnable_q;
  logic xramEnable_q;
  logic aleInhibit_q;
  logic wdtFlag_q;
  logic directSfr;
  logic inWindow;
  logic [11:0] iramPhys;
  logic [15:0] xdataFull;
  logic xdataOnChip;
  logic [11:0] ramAddr;
  logic ramWr;
  logic ramRd;
  logic [7:0] ramWrData;
  logic [7:0] ramRdData_q;
  logic [7:0] sfrRdData_d;
  logic [7:0] sfrRdData_q;
  logic sfrOwn_q;
  logic iramRam_q;
  logic xdataRam_q;

  // Window bank to physical array address
  function automatic logic [11:0] bankToPhys(input logic [5:0] bank, input logic [5:0] ofs);
    logic [11:0] blk;
    blk = {bank, ofs};
    if (bank < BANK_FIRST_XRAM) begin
      return blk;
    end
    return blk - 12'h100 + XRAM_ARRAY_BASE;
  endfunction

  // Direct 80h-FFh belongs to SFR space
  assign directSfr = iramReq && !iramIndirect && iramAddr >= SFR_BASE;
  assign inWindow = !iramIndirect && windowEnable_q && iramAddr >= WIN_BASE && iramAddr <= WIN_LAST;

  // Core address to array address
  always_comb begin
    if (inWindow) begin
      iramPhys = bankToPhys(bankField_q, iramAddr[5:0]);
    end else begin
      iramPhys = {4'h0, iramAddr};
    end
  end

  // External-data address, page field on register-indirect moves
  assign xdataFull = xdataByReg ? {4'h0, pageField_q, xdataAddr[7:0]} : xdataAddr;
  assign xdataOnChip = xramEnable_q && xdataFull <= XRAM_LAST
    && !(xdataByReg && pageField_q == PAGE_INVALID);

  // External bus only when on-chip RAM does not serve it
  assign xdataExtReq = xdataReq && !xdataOnChip;
  assign xdataExtWr = xdataReq && !xdataOnChip && xdataWr;
  assign xdataExtAddr = xdataFull;
  assign xdataExtWrData = xdataWrData;

  // SFR pass-through
  assign sfrReq = directSfr;
  assign sfrWr = directSfr && iramWr;
  assign sfrAddr = iramAddr;
  assign sfrWrData = iramWrData;

  // Array port arbitration: core data access has priority
  always_comb begin
    ramAddr = 12'h000;
    ramWr = 1'b0;
    ramRd = 1'b0;
    ramWrData = iramWrData;
    if (iramReq && !directSfr) begin
      ramAddr = iramPhys;
      ramWr = iramWr;
      ramRd = !iramWr;
    end else if (xdataReq && xdataOnChip) begin
      ramAddr = xdataFull[11:0] + XRAM_ARRAY_BASE;
      ramWr = xdataWr;
      ramRd = !xdataWr;
      ramWrData = xdataWrData;
    end
  end

  rbm_ram #(.AW(12)) uRam (
    .clk_sys(clk_sys),
    .wrEn(ramWr),
    .rdEn(ramRd),
    .addr(ramAddr),
    .wrData(ramWrData),
    .rdData_q(ramRdData_q)
  );

  rbm_sfr_regs uRegs (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .sfrWr(directSfr && iramWr),
    .sfrAddr(iramAddr),
    .sfrWrData(iramWrData),
    .wdtResetSeen(wdtResetSeen),
    .pageField_q(pageField_q),
    .bankField_q(bankField_q),
    .windowEnable_q(windowEnable_q),
    .xramEnable_q(xramEnable_q),
    .aleInhibit_q(aleInhibit_q),
    .wdtFlag_q(wdtFlag_q)
  );

  // Own register readback, unused bits read zero
  always_comb begin
    unique case (iramAddr)
      OFS_PAGE_SELECT: sfrRdData_d = {4'h0, pageField_q};
      OFS_BANK_CONTROL: sfrRdData_d = {windowEnable_q, 1'b0, bankField_q};
      OFS_SYS_CONFIG: sfrRdData_d = {wdtFlag_q, 5'h00, xramEnable_q, aleInhibit_q};
      default: sfrRdData_d = sfrExtRdData;
    endcase
  end

  // Read return bookkeeping
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sfrRdData_q <= 8'h00;
      sfrOwn_q <= 1'b0;
      iramRam_q <= 1'b0;
      xdataRam_q <= 1'b0;
      iramRdValid_q <= 1'b0;
      xdataRdValid_q <= 1'b0;
    end else begin
      sfrRdData_q <= sfrRdData_d;
      sfrOwn_q <= directSfr;
      iramRam_q <= iramReq && !directSfr && !iramWr;
      xdataRam_q <= !(iramReq && !directSfr) && xdataReq && xdataOnChip && !xdataWr;
      iramRdValid_q <= iramReq && !iramWr;
      xdataRdValid_q <= !(iramReq && !directSfr) && xdataReq && xdataOnChip && !xdataWr;
    end
  end

  // Core-side read data
  always_comb begin
    iramRdData_q = sfrOwn_q ? sfrRdData_q : (iramRam_q ? ramRdData_q : 8'h00);
    xdataRdData_q = xdataRam_q ? ramRdData_q : 8'h00;
  end

  assign xramEnable = xramEnable_q;
  assign aleInhibit = aleInhibit_q;
endmodule

// ==== verif/rbm_bank_mapper_assertions.sv ====
`timescale 1ns/10ps
// Port-level checks on answers, routing and enables
module rbm_checker
  import rbm_pkg::*;
(
  input logic clk_sys,
  input logic reset_n,
  input logic iramReq,
  input logic iramIndirect,
  input logic iramWr,
  input logic [7:0] iramAddr,
  input logic [7:0] iramWrData,
  input logic iramRdValid_q,
  input logic xdataReq,
  input logic xdataWr,
  input logic xdataByReg,
  input logic [15:0] xdataAddr,
  input logic [7:0] xdataWrData,
  input logic xdataRdValid_q,
  input logic xdataExtReq,
  input logic xdataExtWr,
  input logic [15:0] xdataExtAddr,
  input logic [7:0] xdataExtWrData,
  input logic sfrReq,
  input logic sfrWr,
  input logic [7:0] sfrAddr,
  input logic [7:0] sfrWrData,
  input logic xramEnable
);
  logic cfgWr;
  logic onChip;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // Decoded strobes
  assign cfgWr = iramReq && iramWr && !iramIndirect && iramAddr == OFS_SYS_CONFIG;
  assign onChip = xdataReq && xramEnable && !xdataByReg && xdataAddr <= XRAM_LAST;
  rd_answer_a: assert property (iramReq && !iramWr |=> iramRdValid_q)
    else $error("no read answer");
  sfr_route_a: assert property (iramReq && !iramIndirect && iramAddr >= SFR_BASE |->
    sfrReq && sfrAddr == iramAddr) else $error("sfr not routed");
  sfr_write_a: assert property (iramReq && iramWr && !iramIndirect && iramAddr >= SFR_BASE |->
    sfrWr && sfrWrData == iramWrData) else $error("sfr write not routed");
  ext_write_a: assert property (xdataReq && xdataWr && !xramEnable |->
    xdataExtWr && xdataExtWrData == xdataWrData) else $error("write not forwarded");
  indirect_ram_a: assert property (iramReq && iramIndirect |-> !sfrReq)
    else $error("indirect went to sfr");
  xram_set_a: assert property (cfgWr |=> xramEnable == $past(iramWrData[1]))
    else $error("xram enable not set");
  xram_hold_a: assert property ($changed(xramEnable) |-> $past(cfgWr))
    else $error("xram enable moved");
  ext_off_a: assert property (xdataReq && !xramEnable && !xdataByReg |->
    xdataExtReq && xdataExtAddr == xdataAddr) else $error("not forwarded");
  onchip_quiet_a: assert property (onChip |-> !xdataExtReq && !xdataExtWr)
    else $error("bus used on chip");
  xrd_answer_a: assert property (onChip && !xdataWr && !iramReq |=> xdataRdValid_q)
    else $error("no xdata answer");
  cover property (iramReq && !iramIndirect && iramAddr inside {[WIN_BASE:WIN_LAST]});
  cover property (xdataRdValid_q);
  cover property (sfrReq);
endmodule
bind rbm_bank_mapper rbm_checker chk_u (.*);

// ==== verif/rbm_core_model.sv ====
`timescale 1ns/10ps
// Core side requester
module rbm_core_model (
  input wire logic clk_sys,
  output logic iramReq,
  output logic iramIndirect,
  output logic iramWr,
  output logic [7:0] iramAddr,
  output logic [7:0] iramWrData,
  output logic xdataReq,
  output logic xdataWr,
  output logic xdataByReg,
  output logic [15:0] xdataAddr,
  output logic [7:0] xdataWrData
);
  // Idle at time zero
  initial begin
    {iramReq, iramIndirect, iramWr, iramAddr, iramWrData} = '0;
    {xdataReq, xdataWr, xdataByReg, xdataAddr, xdataWrData} = '0;
  end
  // One request per call, released address and data inverted
  task automatic go(logic x, logic i, logic w, logic [15:0] a, logic [7:0] d);
    @(posedge clk_sys);
    {iramReq, iramIndirect, iramWr, iramAddr, iramWrData} <= {!x, i, w, a[7:0], d};
    {xdataReq, xdataByReg, xdataWr, xdataAddr, xdataWrData} <= {x, i, w, a, d};
    @(posedge clk_sys);
    {iramReq, xdataReq, iramAddr, xdataAddr} <= {2'b0, ~a[7:0], ~a};
    {iramWrData, xdataWrData} <= ~{d, d};
    #1;
  endtask
endmodule

// ==== verif/onchip_ram_bank_mapper_test.sv ====
`timescale 1ns/10ps
module onchip_ram_bank_mapper_test;
  import rbm_pkg::*;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic wdtResetSeen = 1'b0;
  logic [7:0] sfrExtRdData = 8'h00;
  logic iramReq, iramIndirect, iramWr, iramRdValid_q, xdataReq, xdataWr, xdataByReg;
  logic xdataRdValid_q, xramEnable, aleInhibit, win, en;
  logic [7:0] iramAddr, iramWrData, iramRdData_q, xdataWrData, xdataRdData_q;
  logic [15:0] xdataAddr;
  logic [3:0] pg;
  logic [5:0] bk;
  int mem [int];
  int fail_count = 0;
  int num_checks = 0;
  int cyc = 0;
  int unsigned s = 5;
  rbm_bank_mapper dut_u (.*, .xdataExtReq(), .xdataExtWr(), .xdataExtAddr(), .xdataExtWrData(),
    .sfrReq(), .sfrWr(), .sfrAddr(), .sfrWrData());
  rbm_core_model core_u (.*);
  // Clock
  initial forever #4 clk_sys = ~clk_sys;
  // Hang guard
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      end_of_test();
    end
  end
  function automatic logic [7:0] rnd();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s[7:0];
  endfunction
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  // Register write mirrored in the model
  task automatic wr(logic [7:0] a, logic [7:0] d);
    core_u.go(0, 0, 1, {8'h0, a}, d);
    if (a == OFS_PAGE_SELECT) pg = d[3:0];
    if (a == OFS_BANK_CONTROL) {win, bk} = {d[7], d[5:0]};
    if (a == OFS_SYS_CONFIG) en = d[1];
  endtask
  task automatic rr(logic [7:0] a, logic [7:0] e, logic [7:0] m);
    core_u.go(0, 0, 0, {8'h0, a}, 8'h00);
    chk("reg data", e, iramRdData_q & m);
  endtask
  // Internal access, x is the array byte reached
  task automatic ia(logic i, logic w, logic [7:0] a, logic [7:0] d);
    int x;
    x = (!i && win && a inside {[WIN_BASE:WIN_LAST]}) ? bk * 64 + a[5:0] : a;
    core_u.go(0, i, w, {8'h0, a}, d);
    if (w) mem[x] = d;
    else chk("iram data", mem[x][7:0], iramRdData_q);
    if (!w) chk("iram valid", 8'h01, {7'h0, iramRdValid_q});
  endtask
  // Expanded access, refused ones give no answer
  task automatic xa(logic r, logic w, logic [15:0] a, logic [7:0] d);
    logic [15:0] e;
    int x;
    e = r ? {4'h0, pg, a[7:0]} : a;
    x = (en && e <= XRAM_LAST) ? e + 256 : -1;
    core_u.go(1, r, w, a, d);
    chk("xdata valid", {7'h0, !w && x >= 0}, {7'h0, xdataRdValid_q});
    if (x >= 0 && w) mem[x] = d;
    if (x >= 0 && !w) chk("xdata data", mem[x][7:0], xdataRdData_q);
  endtask
  // Main sequence
  initial begin
    logic [7:0] a;
    logic [5:0] o;
    {pg, bk, win, en} = {4'h0, 6'h01, 2'b00};
    repeat (16) @(posedge clk_sys);
    reset_n <= 1'b1;
    chk("xram enable", 8'h00, {7'h0, xramEnable});
    rr(OFS_BANK_CONTROL, 8'h01, 8'hBF);
    rr(OFS_PAGE_SELECT, 8'h00, 8'h0F);
    rr(OFS_SYS_CONFIG, 8'h00, 8'h83);
    a = rnd();
    sfrExtRdData <= a;
    rr(8'hC8, a, 8'hFF);
    repeat (40) begin
      a = rnd();
      ia(0, 1, {1'b0, a[6:0]}, rnd());
      ia(1, 0, {1'b0, a[6:0]}, 8'h00);
      ia(1, 1, {1'b1, a[6:0]}, rnd());
      ia(0, 0, {1'b0, a[6:0]}, 8'h00);
      ia(1, 0, {1'b1, a[6:0]}, 8'h00);
    end
    ia(0, 1, 8'h45, rnd());
    wr(OFS_SYS_CONFIG, 8'h02);
    chk("xram enable", 8'h01, {7'h0, xramEnable});
    for (int b = 0; b < 64; b++) begin
      o = 6'(rnd());
      wr(OFS_BANK_CONTROL, {2'b10, 6'(b)});
      ia(0, 1, {2'b01, o}, rnd());
      if (b < 4) ia(1, 0, {2'(b), o}, 8'h00);
      else xa(0, 0, 16'(b * 64 + o - 256), 8'h00);
      ia(0, 0, {2'b01, o}, 8'h00);
    end
    rr(OFS_BANK_CONTROL, 8'hBF, 8'hFF);
    wr(OFS_BANK_CONTROL, 8'h04);
    ia(0, 0, 8'h45, 8'h00);
    for (int p = 0; p < 16; p++) begin
      a = rnd();
      wr(OFS_PAGE_SELECT, 8'(p));
      xa(1, 1, {8'h0, a}, rnd());
      xa(0, 0, {4'h0, 4'(p), a}, 8'h00);
    end
    xa(0, 1, 16'h0010, 8'hA5);
    wr(OFS_SYS_CONFIG, 8'h01);
    chk("ale inhibit", 8'h01, {7'h0, aleInhibit});
    xa(0, 1, 16'h0010, 8'h3C);
    wr(OFS_SYS_CONFIG, 8'h02);
    xa(0, 0, 16'h0010, 8'h00);
    // Watchdog event sets the status bit
    @(posedge clk_sys);
    wdtResetSeen <= 1'b1;
    @(posedge clk_sys);
    wdtResetSeen <= 1'b0;
    rr(OFS_SYS_CONFIG, 8'h82, 8'h83);
    end_of_test();
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
endmodule
